// file: wdt_defs.vh
// Constants for the I/O port watchdog timer.
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH
`define WDT_PORT_ADDR 16'h0443
`define WDT_MIN_VALUE 8'h01
`define WDT_MAX_VALUE 8'h3e
`define WDT_TIMEOUT_RESET 8'h00
`define WDT_CLK_HZ 20000000
`define WDT_TICK_SEC 1
`define WDT_TICK_CYCLES (`WDT_CLK_HZ * `WDT_TICK_SEC)
`define WDT_PULSE_CYCLES 16
`endif

// file: sec_tick_gen.v
// Divider, cleared by restart, that produces a one-cycle one-second tick.
`timescale 1ns/1ps
module sec_tick_gen
#(
  parameter integer TICK_CYCLES = 20000000
)
(
  ref_clk,
  rst,
  clk_en,
  restart,
  tick
);
  input wire ref_clk;
  input wire rst;
  input wire clk_en;
  input wire restart;
  output reg tick;

  reg [31:0] cnt_ff;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_ff <= 32'h0;
      tick <= 1'b0;
    end
    else if (clk_en)
    begin
      // Restart aligns the second to the write so a full interval elapses.
      if (restart || cnt_ff == TICK_CYCLES - 1)
        cnt_ff <= 32'h0;
      else
        cnt_ff <= cnt_ff + 32'h1;
      tick <= !restart && (cnt_ff == TICK_CYCLES - 1);
    end
  end
endmodule

// file: io_port_watchdog_timer.v
// Watchdog timer reached through one byte-wide I/O port.
`timescale 1ns/1ps
`include "wdt_defs.vh"
module io_port_watchdog_timer
#(
  parameter integer TICK_CYCLES = `WDT_TICK_CYCLES,
  parameter integer PULSE_CYCLES = `WDT_PULSE_CYCLES
)
(
  ref_clk,
  rst,
  clk_en,
  io_addr,
  io_wr,
  io_rd,
  io_wdata,
  io_rdata,
  action_irq,
  cpu_reset,
  wdt_irq,
  wdt_running
);
  input wire ref_clk;
  input wire rst;
  input wire clk_en;
  input wire [15:0] io_addr;
  input wire io_wr;
  input wire io_rd;
  input wire [7:0] io_wdata;
  output reg [7:0] io_rdata;
  input wire action_irq;
  output reg cpu_reset;
  output reg wdt_irq;
  output reg wdt_running;

  // ----------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------
  wire hit = (io_addr == `WDT_PORT_ADDR);
  wire wr_hit = hit && io_wr;
  wire rd_hit = hit && io_rd && !io_wr;

  reg [7:0] remain_ff;
  reg [7:0] timeout_ff;
  reg [7:0] pulse_ff;
  reg fire_irq_ff;
  reg act_s1_ff;
  reg act_s2_ff;
  reg act_s3_ff;
  reg act_lvl_ff;
  wire tick;
  wire expire;

  sec_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .restart(wr_hit),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Action select synchroniser
  // ----------------------------------------------------------------
  // The action select comes from a board pin, so it passes three flops.
  // A new level is taken only once the second and third flops agree,
  // which costs a few cycles but keeps a glitch from choosing the action.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      act_s1_ff <= 1'b0;
      act_s2_ff <= 1'b0;
      act_s3_ff <= 1'b0;
      act_lvl_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      act_s1_ff <= action_irq;
      act_s2_ff <= act_s1_ff;
      act_s3_ff <= act_s2_ff;
      if (act_s2_ff == act_s3_ff)
        act_lvl_ff <= act_s3_ff;
    end
  end

  // ----------------------------------------------------------------
  // Expiry detect
  // ----------------------------------------------------------------
  // A port access in the same cycle as the last tick takes precedence,
  // so a refresh that arrives just in time never fires the action.
  // last second ends
  assign expire = wdt_running && tick && (remain_ff == 8'h01) &&
    !wr_hit && !rd_hit;

  // ----------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      remain_ff <= `WDT_TIMEOUT_RESET;
      timeout_ff <= `WDT_TIMEOUT_RESET;
      wdt_running <= 1'b0;
      io_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      if (wr_hit)
      begin
        timeout_ff <= io_wdata;
        remain_ff <= io_wdata;
        // A zero value cannot count a second, so it leaves the timer off.
        wdt_running <= (io_wdata != 8'h00);
      end
      else if (rd_hit)
      begin
        wdt_running <= 1'b0;
        io_rdata <= timeout_ff;
      end
      else if (wdt_running && tick)
      begin
        if (expire)
          wdt_running <= 1'b0;
        remain_ff <= remain_ff - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Action pulse
  // ----------------------------------------------------------------
  // The pulse has a fixed length so that the reset logic downstream
  // sees a clean event even if software never touches the port again.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      pulse_ff <= 8'h00;
      fire_irq_ff <= 1'b0;
      cpu_reset <= 1'b0;
      wdt_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      if (expire)
      begin
        pulse_ff <= PULSE_CYCLES[7:0];
        fire_irq_ff <= act_lvl_ff;
      end
      else if (pulse_ff != 8'h00)
      begin
        pulse_ff <= pulse_ff - 8'h01;
      end
      cpu_reset <= (pulse_ff != 8'h00) && !fire_irq_ff;
      wdt_irq <= (pulse_ff != 8'h00) && fire_irq_ff;
    end
  end
endmodule

// file: wdt_monitor.sv
// Assertions on the watchdog port and outputs.
`timescale 1ns/1ps
module wdt_monitor(input wire ref_clk, rst, clk_en, io_wr, io_rd,
  input wire [15:0] io_addr, input wire [7:0] io_wdata,
  input wire cpu_reset, wdt_irq, wdt_running);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire hit = clk_en && io_addr == 16'h0443;
  sequence s_wr; hit && io_wr; endsequence
  property p_wr; s_wr ##0 io_wdata != 8'h00 |=> wdt_running; endproperty
  a_wr: assert property(p_wr) else $error("no run");
  property p_zero; s_wr ##0 io_wdata == 8'h00 |=> !wdt_running; endproperty
  a_zero: assert property(p_zero) else $error("zero ran");
  property p_rd; hit && io_rd && !io_wr |=> !wdt_running; endproperty
  a_rd: assert property(p_rd) else $error("read ran");
  property p_one; !(cpu_reset && wdt_irq); endproperty
  a_one: assert property(p_one) else $error("both fired");
  // Expiry may only follow a live countdown, never a disabled one.
  property p_exp;
    $rose(cpu_reset) || $rose(wdt_irq) |-> $past(wdt_running, 2);
  endproperty
  a_exp: assert property(p_exp) else $error("idle fire");
  property p_pls; $rose(cpu_reset) |-> cpu_reset[*8]; endproperty
  a_pls: assert property(p_pls) else $error("short");
endmodule

// file: io_port_watchdog_timer_tb_top.sv
// Self-checking bench for the watchdog port.
`timescale 1ns/1ps
module io_port_watchdog_timer_tb_top;
  reg clk=0, rst=1, wr=0, rd=0, act=0;
  reg [15:0] a=0;
  reg [7:0] d=0;
  wire [7:0] q;
  wire cr, ir, run;
  integer failures=0, compares=0, seed=32'h50fdcf18, n, k, i;
  // A short tick keeps each timeout to a few cycles.
  io_port_watchdog_timer #(.TICK_CYCLES(4)) DUT(.ref_clk(clk), .rst(rst),
    .clk_en(1'b1), .io_addr(a), .io_wr(wr), .io_rd(rd), .io_wdata(d),
    .io_rdata(q), .action_irq(act), .cpu_reset(cr), .wdt_irq(ir),
    .wdt_running(run));
  task chk(input [31:0] s, e);
    begin
      compares=compares+1;
      if (s!==e)
      begin
        failures=failures+1;
        $display("[ERR] %0t got %0h want %0h", $time, s, e);
      end
    end
  endtask
  task acc(input [15:0] x, input w, r, input [7:0] v);
    begin
      @(negedge clk) {a, wr, rd, d}={x, w, r, v};
      @(negedge clk) {wr, rd}=0;
    end
  endtask
  task wt;
    for (k=0; !(cr|ir) && k<400; k=k+1) @(negedge clk);
  endtask
  task results;
    begin
      $display("failures %0d compares %0d", failures, compares);
      if (failures==0 && compares>0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial forever #25 clk=~clk;
  initial
  begin
    #300000 failures=failures+1;
    results;
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rst=0;
    for (i=0; i<6; i=i+1)
    begin
      n={$random(seed)}%3+1;
      act=$random(seed);
      acc(16'h0443, 1, 0, 8'h3e);
      repeat (n) @(negedge clk);
      acc(16'h0443, 1, i[0], n[7:0]);
      wt;
      chk(k, n*4+2);
      chk({cr, ir}, {!act, act});
      repeat (20) @(negedge clk);
    end
    acc(16'h0442, 1, 0, 8'h01);
    acc(16'h0443, 1, 0, 8'h00);
    chk(run, 0);
    wt;
    chk(k, 400);
    acc(16'h0443, 1, 0, 8'h02);
    chk(run, 1);
    acc(16'h0443, 0, 1, 8'h00);
    chk(run, 0);
    wt;
    chk(k, 400);
    chk(q, 8'h02);
    results;
  end
endmodule
bind io_port_watchdog_timer wdt_monitor mon(.*);
